// >>> design/spsd_decode.v
// How it works
// - An 8-bit page register at 0xa7 picks the page every access decodes on.
// - After reset the page register holds zero, so page 0x0 is in use.
// - Shared registers, page register included, decode alike on any page.
// - One address in 0x80..0xff may reach different registers by page.
// - 0xba is burst power-up time on page 0xf, accum config on page 0x0.
// - 0x97 is checksum sector count on page 0xf, dc-dc control on 0x0.
// - 0xa4 is port 0 drive strength on page 0xf, output mode on 0x0.
// - Only addresses ending in 0x0 or 0x8 accept single-bit access.
`timescale 1ns/1ps
`include "spsd_consts.vh"

module spsd_decode #(
  parameter AW = 8,
  parameter DW = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Core request
  input wire [AW-1:0] core_addr,
  input wire core_rd,
  input wire core_wr,
  input wire [DW-1:0] core_wdata,
  input wire core_bit_en,
  input wire [2:0] core_bit_idx,
  // Core answer
  output reg [DW-1:0] core_rdata,
  output reg core_ack,
  output reg core_fault,
  // Peripheral strobes
  output wire periph_rd,
  output wire periph_wr,
  output wire [AW-1:0] periph_addr,
  output wire [1:0] periph_bank,
  output wire [DW-1:0] periph_wdata,
  output wire periph_bit_en,
  output wire [2:0] periph_bit_idx,
  input wire [DW-1:0] periph_rdata,
  // Named selects for paired locations
  output wire sel_burst_powerup,
  output wire sel_accum_config,
  output wire sel_sector_count,
  output wire sel_dcdc_control,
  output wire sel_drive_strength,
  output wire sel_output_mode,
  // Current page
  output wire [DW-1:0] page_value
);

  reg rst_s1_reg;
  reg rst_s2_reg;
  wire rst_sync_n;
  wire [DW-1:0] page_q;
  reg shared_hit;
  reg high_hit;
  wire space_hit;
  wire zero_hit;
  wire on_zero;
  wire on_high;
  reg [1:0] bank;
  wire bit_ok;
  wire req;
  wire legal;
  wire page_hit;
  wire page_wr;
  wire [DW-1:0] page_wdata;
  wire [DW-1:0] bit_mask;
  reg [DW-1:0] rdata_next;

  // Reset release through two flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  assign rst_sync_n = rst_s2_reg;

  // Locations present on every page
  // shared register set
  always @* begin
    shared_hit = 1'b0;
    case (core_addr)
      8'h80: shared_hit = 1'b1;
      8'h81: shared_hit = 1'b1;
      8'h82: shared_hit = 1'b1;
      8'h83: shared_hit = 1'b1;
      8'h87: shared_hit = 1'b1;
      8'h90: shared_hit = 1'b1;
      8'ha0: shared_hit = 1'b1;
      8'ha7: shared_hit = 1'b1;
      8'ha8: shared_hit = 1'b1;
      8'ha9: shared_hit = 1'b1;
      8'hd0: shared_hit = 1'b1;
      8'he0: shared_hit = 1'b1;
      8'he6: shared_hit = 1'b1;
      8'he7: shared_hit = 1'b1;
      8'hf0: shared_hit = 1'b1;
      8'hf6: shared_hit = 1'b1;
      8'hf7: shared_hit = 1'b1;
      default: shared_hit = 1'b0;
    endcase
  end

  // Locations owned by page 0xf, also decoded by page zero
  // same address, other register
  always @* begin
    high_hit = 1'b0;
    case (core_addr)
      8'h85: high_hit = 1'b1;
      8'h86: high_hit = 1'b1;
      8'h91: high_hit = 1'b1;
      8'h92: high_hit = 1'b1;
      8'h93: high_hit = 1'b1;
      8'h95: high_hit = 1'b1;
      8'h96: high_hit = 1'b1;
      8'h97: high_hit = 1'b1;
      8'ha4: high_hit = 1'b1;
      8'ha5: high_hit = 1'b1;
      8'ha6: high_hit = 1'b1;
      8'hba: high_hit = 1'b1;
      8'hbd: high_hit = 1'b1;
      default: high_hit = 1'b0;
    endcase
  end

  // Page zero owns every other location except two holes
  assign space_hit = core_addr[`SPSD_SPACE_BIT];
  assign zero_hit = space_hit && !shared_hit &&
                    (core_addr != `SPSD_HOLE_A) &&
                    (core_addr != `SPSD_HOLE_B);

  // Full page value compared, no partial decode
  // whole byte selects page
  assign on_zero = (page_q == `SPSD_PAGE_ZERO);
  assign on_high = (page_q == `SPSD_PAGE_HIGH);

  // Bank resolution for the current access
  // foreign page, shared only
  always @* begin
    if (space_hit && shared_hit) begin
      bank = `SPSD_BANK_SHARED;
    end else if (on_zero && zero_hit) begin
      bank = `SPSD_BANK_ZERO;
    end else if (on_high && high_hit) begin
      bank = `SPSD_BANK_HIGH;
    end else begin
      bank = `SPSD_BANK_NONE;
    end
  end

  // Single-bit access only on bit-addressable locations
  // bit access gate
  assign bit_ok = !core_bit_en ||
                  (core_addr[2:0] == `SPSD_BIT_MASK);

  assign req = core_rd || core_wr;
  assign legal = (bank != `SPSD_BANK_NONE) && bit_ok;
  assign page_hit = (core_addr == `SPSD_PAGE_ADDR);

  // Page register write, whole byte only
  // page register write
  assign page_wr = core_wr && legal && page_hit;
  assign bit_mask = {{(DW-1){1'b0}}, 1'b1} << core_bit_idx;
  assign page_wdata = core_wdata;

  spsd_page_reg #(
    .WIDTH(DW)
  ) u_page (
    .clk(clk),
    .rst_n(rst_sync_n),
    .wr_en(page_wr),
    .wr_data(page_wdata),
    .value(page_q)
  );

  // Forward legal accesses, page register kept local
  assign periph_rd = core_rd && legal && !page_hit;
  assign periph_wr = core_wr && legal && !page_hit;
  assign periph_addr = core_addr;
  assign periph_bank = legal ? bank : `SPSD_BANK_NONE;
  assign periph_wdata = core_wdata;
  assign periph_bit_en = core_bit_en;
  assign periph_bit_idx = core_bit_idx;

  // Converter pair at 0xba
  // converter pair
  assign sel_burst_powerup = legal && on_high &&
                             (core_addr == `SPSD_ADDR_CONV);
  assign sel_accum_config = legal && on_zero &&
                            (core_addr == `SPSD_ADDR_CONV);

  // Checksum and dc-dc pair at 0x97
  // sector count pair
  assign sel_sector_count = legal && on_high &&
                            (core_addr == `SPSD_ADDR_CSUM);
  assign sel_dcdc_control = legal && on_zero &&
                            (core_addr == `SPSD_ADDR_CSUM);

  // Port 0 pair at 0xa4
  // port 0 pair
  assign sel_drive_strength = legal && on_high &&
                              (core_addr == `SPSD_ADDR_PORT0);
  assign sel_output_mode = legal && on_zero &&
                           (core_addr == `SPSD_ADDR_PORT0);

  // Read data choice; reserved places read as zero
  always @* begin
    rdata_next = {DW{1'b0}};
    if (core_rd && legal) begin
      if (page_hit) begin
        rdata_next = page_q;
      end else begin
        rdata_next = periph_rdata;
      end
      if (core_bit_en) begin
        rdata_next = rdata_next & bit_mask;
      end
    end
  end

  // Answer registered one cycle after the request
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      core_rdata <= {DW{1'b0}};
      core_ack <= 1'b0;
      core_fault <= 1'b0;
    end else begin
      core_ack <= req;
      core_fault <= req && !legal;
      if (core_rd) begin
        core_rdata <= rdata_next;
      end
    end
  end

  assign page_value = page_q;

endmodule // spsd_decode

// >>> common/spsd_consts.vh
`ifndef SPSD_CONSTS_VH
`define SPSD_CONSTS_VH

// Page register location and reset value
`define SPSD_PAGE_ADDR 8'ha7
`define SPSD_PAGE_RST 8'h00

// Page codes that own registers
`define SPSD_PAGE_ZERO 8'h00
`define SPSD_PAGE_HIGH 8'h0f

// Address bit that marks the direct register space
`define SPSD_SPACE_BIT 7

// Bank codes presented to the peripherals
`define SPSD_BANK_NONE 2'h0
`define SPSD_BANK_SHARED 2'h1
`define SPSD_BANK_ZERO 2'h2
`define SPSD_BANK_HIGH 2'h3

// Paired addresses whose meaning follows the page
`define SPSD_ADDR_CONV 8'hba
`define SPSD_ADDR_CSUM 8'h97
`define SPSD_ADDR_PORT0 8'ha4

// Unoccupied locations of page zero
`define SPSD_HOLE_A 8'hb4
`define SPSD_HOLE_B 8'he5

// Bit-addressable locations end in this low three-bit pattern
`define SPSD_BIT_MASK 3'h0

`endif

// >>> design/spsd_page_reg.v
`timescale 1ns/1ps
`include "spsd_consts.vh"

module spsd_page_reg #(
  parameter WIDTH = 8
) (
  // Clock and synchronised reset
  input wire clk,
  input wire rst_n,
  // Write port
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  // Stored value
  output wire [WIDTH-1:0] value
);

  reg [WIDTH-1:0] page_reg;

  // Page register storage, cleared to page zero
  // reset page zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_reg <= `SPSD_PAGE_RST;
    end else if (wr_en) begin
      page_reg <= wr_data;
    end
  end

  assign value = page_reg;

endmodule // spsd_page_reg

// >>> verif/spsd_periph_model.sv
`timescale 1ns/1ps
// Peripheral stand-in, answers in the request cycle
module spsd_periph_model (
  // Request
  input wire [7:0] periph_addr,
  input wire [1:0] periph_bank,
  // Answer
  output wire [7:0] periph_rdata
);
  // reserved places unused: bank none reads as zero upstream
  // Pattern of address and bank, so a wrong bank shows
  assign periph_rdata = periph_addr ^ {6'h0, periph_bank};
endmodule // spsd_periph_model

// >>> verif/spsd_decode_props.sv
`timescale 1ns/1ps
module spsd_decode_props (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Core side
  input wire [7:0] core_addr,
  input wire core_rd,
  input wire core_wr,
  input wire [7:0] core_wdata,
  input wire core_bit_en,
  input wire core_ack,
  input wire core_fault,
  // Decode side
  input wire periph_rd,
  input wire periph_wr,
  input wire [1:0] periph_bank,
  input wire sel_burst_powerup,
  input wire sel_accum_config,
  input wire sel_sector_count,
  input wire sel_dcdc_control,
  input wire sel_drive_strength,
  input wire sel_output_mode,
  input wire [7:0] page_value
);
  // Byte request and page flags
  wire rq = (core_rd | core_wr) & ~core_bit_en;
  wire [7:0] a = core_addr;
  // Selects follow the address even between strobes
  wire by = ~core_bit_en;
  wire p0 = page_value == 8'h00;
  wire pf = page_value == 8'h0f;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_ack_follows: assert property ((core_rd | core_wr) |=> core_ack)
    else $error("ack missing");
  chk_ack_idle: assert property (!(core_rd | core_wr) |=> !core_ack)
    else $error("stray ack");
  chk_page_write: assert property (rq && !core_rd && a == 8'ha7
    |=> page_value == $past(core_wdata)) else $error("page not written");
  chk_page_reset: assert property (disable iff (1'b0)
    $rose(rst_n) |-> p0) else $error("page not zero after reset");
  chk_conv_pair: assert property (sel_burst_powerup == (by && a == 8'hba
    && pf) && sel_accum_config == (by && a == 8'hba && p0))
    else $error("0xba select wrong");
  chk_csum_pair: assert property (sel_sector_count == (by && a == 8'h97
    && pf) && sel_dcdc_control == (by && a == 8'h97 && p0))
    else $error("0x97 select wrong");
  chk_port_pair: assert property (sel_drive_strength == (by && a == 8'ha4
    && pf) && sel_output_mode == (by && a == 8'ha4 && p0))
    else $error("0xa4 select wrong");
  chk_page_local: assert property (a == 8'ha7
    |-> !periph_rd && !periph_wr) else $error("page reg access forwarded");
  chk_odd_page: assert property (periph_rd && !p0 && !pf
    |-> periph_bank == 2'h1) else $error("odd page reached paged reg");
  chk_bit_refuse: assert property ((core_rd | core_wr) && core_bit_en
    && a[2:0] != 3'h0 |-> !periph_rd ##1 core_fault)
    else $error("bit access not refused");
endmodule // spsd_decode_props
bind spsd_decode spsd_decode_props i_props (.*);

// >>> verif/tb_sfr_page_select_decode.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  miscompares++; $display("CHECK FAILED t=%0t %h %h", $time, g, e); end end
module tb_sfr_page_select_decode;
  logic clk = 0;
  logic rst_n = 0;
  logic [7:0] core_addr = 0, core_wdata = 0, pg, ra, ex;
  logic core_rd = 0, core_wr = 0, core_bit_en = 0, cap_rd, cap_wr;
  logic [19:0] cap_pass;
  logic [2:0] core_bit_idx = 3'h1;
  logic [3:0] nb;
  logic [1:0] cap_bank;
  wire [7:0] core_rdata, periph_addr, periph_wdata, periph_rdata, page_value;
  wire [2:0] periph_bit_idx;
  wire [1:0] periph_bank;
  wire core_ack, core_fault, periph_rd, periph_wr, periph_bit_en;
  int miscompares = 0, samples_checked = 0;
  // Rows: page, address, {bit, fault, bank}
  logic [19:0] rows [15] = '{20'h00ba2, 20'h0fba3, 20'h00972, 20'h0f973,
    20'h00a42, 20'h0fa43, 20'h0fe01, 20'h05e01, 20'h05ba4, 20'h00b44,
    20'h00404, 20'h0088a, 20'h0089c, 20'h0f853, 20'h05809};
  always #5 clk = ~clk;
  spsd_decode i_dut (.clk, .rst_n, .core_addr, .core_rd, .core_wr,
    .core_wdata, .core_bit_en, .core_bit_idx, .core_rdata, .core_ack,
    .core_fault, .periph_rd, .periph_wr, .periph_addr, .periph_bank,
    .periph_wdata, .periph_bit_en, .periph_bit_idx, .periph_rdata,
    .sel_burst_powerup(), .sel_accum_config(), .sel_sector_count(),
    .sel_dcdc_control(), .sel_drive_strength(), .sel_output_mode(),
    .page_value);
  spsd_periph_model i_model (.periph_addr, .periph_bank, .periph_rdata);
  // One access, strobes captured in the request cycle
  task automatic acc(input logic r, w, b, input logic [7:0] a, d);
    @(posedge clk);
    #1 {core_rd, core_wr, core_bit_en, core_addr, core_wdata} = {r, w, b, a, d};
    #1 cap_rd = periph_rd;
    cap_wr = periph_wr;
    cap_bank = periph_bank;
    cap_pass = {periph_addr, periph_wdata, periph_bit_en, periph_bit_idx};
    @(posedge clk);
    #1 {core_rd, core_wr} = 2'b00;
    `CHK(core_ack, 1'b1)
  endtask
  task automatic rst;
    #1 rst_n = 0;
    repeat (5) @(posedge clk);
    `CHK(page_value, 8'h00)
    #1 rst_n = 1;
    repeat (3) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000 miscompares++;
    print_verdict;
  end
  initial begin
    rst;
    foreach (rows[i]) begin
      {pg, ra, nb} = rows[i];
      acc(0, 1, 0, 8'ha7, pg);
      `CHK(cap_wr, 1'b0)
      `CHK(page_value, pg)
      acc(1, 0, nb[3], ra, 8'h00);
      ex = nb[2] ? 8'h00 : ra ^ {6'h0, nb[1:0]};
      if (nb[3]) ex = ex & 8'h02;
      `CHK(core_fault, nb[2])
      `CHK(cap_rd, !nb[2])
      if (!nb[2]) `CHK(cap_bank, nb[1:0])
      `CHK(core_rdata, ex)
    end
    // page 0xf visit bracketed, page 0x0 written back
    acc(0, 1, 0, 8'ha7, 8'h0f);
    acc(1, 1, 0, 8'h97, 8'h5a);
    `CHK({cap_rd, cap_wr, cap_bank}, 4'hf)
    `CHK(cap_pass, {8'h97, 8'h5a, 1'b0, 3'h1})
    `CHK(core_rdata, 8'h94)
    acc(0, 1, 0, 8'ha7, 8'h00);
    `CHK(page_value, 8'h00)
    // Bit read of the top bit, bit write forwarded
    core_bit_idx = 3'h7;
    acc(1, 0, 1, 8'h80, 8'h00);
    `CHK(core_rdata, 8'h80)
    `CHK(cap_pass, {8'h80, 8'h00, 1'b1, 3'h7})
    acc(0, 1, 1, 8'h88, 8'hff);
    `CHK({cap_wr, cap_bank}, 3'h6)
    `CHK(core_fault, 1'b0)
    // Page register seen on an odd page, bit write refused
    acc(0, 1, 0, 8'ha7, 8'h05);
    acc(1, 0, 0, 8'ha7, 8'h00);
    `CHK(core_rdata, 8'h05)
    acc(0, 1, 1, 8'ha7, 8'h00);
    `CHK(core_fault, 1'b1)
    `CHK(page_value, 8'h05)
    // Reset in mid-run returns to page zero
    rst;
    acc(1, 0, 0, 8'ha7, 8'h00);
    `CHK(core_rdata, 8'h00)
    print_verdict;
  end
endmodule // tb_sfr_page_select_decode
